// *** hdl/toc_compare_unit.sv ***
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module toc_compare_unit (
    input wire logic clk_sys,         // System clock, 100 MHz
    input wire logic rst_n,           // Synchronous reset, active low
    input wire logic psel,            // APB select
    input wire logic penable,         // APB access phase
    input wire logic pwrite,          // APB write
    input wire logic [7:0] paddr,     // APB byte address
    input wire logic [31:0] pwdata,   // APB write data
    output logic [31:0] prdata,       // APB read data
    output logic pready,              // APB ready
    output logic pslverr,             // APB error, unmapped address
    input wire logic portDataA,       // Normal port level, pin A
    input wire logic portDirA,        // Port direction bit, pin A
    input wire logic portDataB,       // Normal port level, pin B
    input wire logic portDirB,        // Port direction bit, pin B
    output logic pinOutA,             // Pin A output level
    output logic pinOeA,              // Pin A output enable
    output logic pinOutB,             // Pin B output level
    output logic pinOeB,              // Pin B output enable
    output logic irq                  // Level interrupt
);

    // ==========================================================
    // State
    // ==========================================================
    logic [7:0] ctrlA_q, ctrlA_d;
    logic [3:0] ctrlB_q, ctrlB_d;
    logic [7:0] count_q, count_d;
    logic countUp_q, countUp_d;
    logic [7:0] cmpBufA_q, cmpBufA_d;
    logic [7:0] cmpBufB_q, cmpBufB_d;
    logic [7:0] cmpA_q, cmpA_d;
    logic [7:0] cmpB_q, cmpB_d;
    logic blockMatch_q, blockMatch_d;
    logic waveA_q, waveA_d;
    logic waveB_q, waveB_d;
    logic [2:0] status_q, status_d;
    logic [2:0] mask_q, mask_d;
    logic [7:0] div_q, div_d;

    // ==========================================================
    // Decode of mode and bus strobes
    // ==========================================================
    logic [2:0] wgm;
    logic [2:0] clkSel;
    logic [1:0] actA;
    logic [1:0] actB;
    logic pwmMode;
    logic fastPwm;
    logic phasePwm;
    logic topIsA;
    logic [7:0] topVal;
    logic busWr;
    logic busRd;
    logic tick;
    logic matchA;
    logic matchB;
    logic atTop;
    logic atBottom;
    logic bufLoad;
    logic forceA;
    logic forceB;
    logic wrCount;

    assign wgm = {ctrlB_q[toc_pkg::WGM_HI_BIT], ctrlA_q[toc_pkg::WGM_LO_LSB +: 2]};
    assign clkSel = ctrlB_q[toc_pkg::CLKSEL_LSB +: 3];
    // Action fields are read straight from the register, no shadow
    assign actA = ctrlA_q[toc_pkg::ACT_A_LSB +: 2];
    assign actB = ctrlA_q[toc_pkg::ACT_B_LSB +: 2];
    // Odd mode codes are the PWM modes; 4 and 6 behave as normal
    assign pwmMode = wgm[0];
    assign fastPwm = (wgm[1:0] == 2'h3);
    assign phasePwm = (wgm[1:0] == 2'h1);
    assign topIsA = (wgm == toc_pkg::WGM_CTC) || (pwmMode && wgm[2]);
    assign topVal = topIsA ? cmpA_q : toc_pkg::CNT_MAX;
    assign atTop = (count_q == topVal);
    assign atBottom = (count_q == toc_pkg::CNT_BOTTOM);

    // Zero-wait slave: every access completes in its first access cycle
    assign busWr = psel && penable && pwrite;
    assign busRd = psel && penable && !pwrite;
    assign wrCount = busWr && (paddr == toc_pkg::OFS_COUNT);
    assign forceA = busWr && (paddr == toc_pkg::OFS_CTRL_B)
                    && pwdata[toc_pkg::FORCE_A_BIT] && !pwmMode;
    assign forceB = busWr && (paddr == toc_pkg::OFS_CTRL_B)
                    && pwdata[toc_pkg::FORCE_B_BIT] && !pwmMode;

    // Timer clock enable from the free-running prescaler
    always_comb begin
        unique case (clkSel)
            toc_pkg::CLK_STOP: tick = 1'b0;
            toc_pkg::CLK_DIV1: tick = 1'b1;
            toc_pkg::CLK_DIV8: tick = (div_q[2:0] == toc_pkg::DIV8_LAST);
            toc_pkg::CLK_DIV64: tick = (div_q[5:0] == toc_pkg::DIV64_LAST);
            default: tick = (div_q == toc_pkg::DIV256_LAST);
        endcase
    end

    // Compare hits, masked in the tick after a counter write
    assign matchA = tick && !blockMatch_q && (count_q == cmpA_q);
    assign matchB = tick && !blockMatch_q && (count_q == cmpB_q);

    // Buffered values move in at top for fast PWM, at top while counting up for phase PWM
    assign bufLoad = tick && ((fastPwm && atTop)
                              || (phasePwm && atTop && countUp_q));

    // ==========================================================
    // Waveform action for one channel on a match
    // ==========================================================
    function automatic logic waveOnMatch(
        input logic cur,
        input logic [1:0] act,
        input logic isPwm,
        input logic isPhase,
        input logic up,
        input logic canToggle
    );
        logic res;
        res = cur;
        if (!isPwm) begin
            unique case (act)
                toc_pkg::ACT_OFF: res = cur;
                toc_pkg::ACT_TOGGLE: res = !cur;
                toc_pkg::ACT_CLEAR: res = 1'b0;
                toc_pkg::ACT_SET: res = 1'b1;
            endcase
        end else begin
            unique case (act)
                toc_pkg::ACT_OFF: res = cur;
                toc_pkg::ACT_TOGGLE: res = canToggle ? !cur : cur;
                toc_pkg::ACT_CLEAR: res = (isPhase && !up) ? 1'b1 : 1'b0;
                toc_pkg::ACT_SET: res = (isPhase && !up) ? 1'b0 : 1'b1;
            endcase
        end
        return res;
    endfunction

    // Fast PWM restores the idle level when the count wraps to bottom
    function automatic logic waveAtWrap(
        input logic cur,
        input logic [1:0] act
    );
        logic res;
        res = cur;
        if (act == toc_pkg::ACT_CLEAR) begin
            res = 1'b1;
        end else if (act == toc_pkg::ACT_SET) begin
            res = 1'b0;
        end
        return res;
    endfunction

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Counter, compare registers, waveform bits and flags together
    always_comb begin
        logic wrapEvt;
        wrapEvt = 1'b0;
        ctrlA_d = ctrlA_q;
        ctrlB_d = ctrlB_q;
        count_d = count_q;
        countUp_d = countUp_q;
        cmpBufA_d = cmpBufA_q;
        cmpBufB_d = cmpBufB_q;
        cmpA_d = cmpA_q;
        cmpB_d = cmpB_q;
        blockMatch_d = blockMatch_q;
        waveA_d = waveA_q;
        waveB_d = waveB_q;
        status_d = status_q;
        mask_d = mask_q;
        div_d = div_q + 8'h01;

        // Counting sequence on each timer tick
        if (tick) begin
            blockMatch_d = 1'b0;
            if (phasePwm) begin
                if (countUp_q) begin
                    if (atTop) begin
                        countUp_d = 1'b0;
                        count_d = count_q - 8'h01;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end else if (atBottom) begin
                    countUp_d = 1'b1;
                    count_d = count_q + 8'h01;
                    wrapEvt = 1'b1;
                end else begin
                    count_d = count_q - 8'h01;
                end
            end else if (atTop) begin
                // Every mode but phase PWM restarts from bottom here, at its top value
                count_d = toc_pkg::CNT_BOTTOM;
                wrapEvt = 1'b1;
            end else begin
                count_d = count_q + 8'h01;
            end
        end

        // Buffer transfer; otherwise only a CPU write outside PWM modes sets the active value
        if (bufLoad) begin
            cmpA_d = cmpBufA_q;
            cmpB_d = cmpBufB_q;
        end

        // Waveform bits: wrap first, a match at the same tick wins
        if (fastPwm && wrapEvt) begin
            waveA_d = waveAtWrap(waveA_q, actA);
            waveB_d = waveAtWrap(waveB_q, actB);
        end
        if (matchA) begin
            waveA_d = waveOnMatch(waveA_d, actA, pwmMode, phasePwm, countUp_q, wgm[2]);
        end
        if (matchB) begin
            waveB_d = waveOnMatch(waveB_d, actB, pwmMode, phasePwm, countUp_q, 1'b0);
        end
        // Forced compare changes only the waveform bit
        if (forceA) begin
            waveA_d = waveOnMatch(waveA_q, actA, 1'b0, 1'b0, 1'b1, 1'b1);
        end
        if (forceB) begin
            waveB_d = waveOnMatch(waveB_q, actB, 1'b0, 1'b0, 1'b1, 1'b1);
        end

        // Read of status clears it, but events of this cycle stay set
        if (busRd && paddr == toc_pkg::OFS_STATUS) begin
            status_d = toc_pkg::RST_EVT;
        end
        if (matchA) begin
            status_d[toc_pkg::EVT_MATCH_A] = 1'b1;
        end
        if (matchB) begin
            status_d[toc_pkg::EVT_MATCH_B] = 1'b1;
        end
        if (wrapEvt) begin
            status_d[toc_pkg::EVT_OVERFLOW] = 1'b1;
        end

        // Register writes; the CPU beats the counting sequence
        if (busWr) begin
            unique case (paddr)
                toc_pkg::OFS_CTRL_A: ctrlA_d = pwdata[7:0];
                toc_pkg::OFS_CTRL_B: begin
                    ctrlB_d[toc_pkg::WGM_HI_BIT] = pwdata[toc_pkg::WGM_HI_BIT];
                    ctrlB_d[toc_pkg::CLKSEL_LSB +: 3] = pwdata[toc_pkg::CLKSEL_LSB +: 3];
                end
                toc_pkg::OFS_COUNT: begin
                    count_d = pwdata[7:0];
                    blockMatch_d = 1'b1;
                end
                toc_pkg::OFS_CMP_A: begin
                    cmpBufA_d = pwdata[7:0];
                    if (!pwmMode) begin
                        cmpA_d = pwdata[7:0];
                    end
                end
                toc_pkg::OFS_CMP_B: begin
                    cmpBufB_d = pwdata[7:0];
                    if (!pwmMode) begin
                        cmpB_d = pwdata[7:0];
                    end
                end
                toc_pkg::OFS_MASK: mask_d = pwdata[2:0];
                default: mask_d = mask_q;
            endcase
        end
    end

    // Registering only; mode changes leave waveform bits alone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrlA_q <= toc_pkg::RST_CTRL_A;
            ctrlB_q <= toc_pkg::RST_CTRL_B;
            count_q <= toc_pkg::RST_COUNT;
            countUp_q <= 1'b1;
            cmpBufA_q <= toc_pkg::RST_CMP;
            cmpBufB_q <= toc_pkg::RST_CMP;
            cmpA_q <= toc_pkg::RST_CMP;
            cmpB_q <= toc_pkg::RST_CMP;
            blockMatch_q <= 1'b0;
            waveA_q <= toc_pkg::RST_WAVE;
            waveB_q <= toc_pkg::RST_WAVE;
            status_q <= toc_pkg::RST_EVT;
            mask_q <= toc_pkg::RST_EVT;
            div_q <= 8'h00;
        end else begin
            ctrlA_q <= ctrlA_d;
            ctrlB_q <= ctrlB_d;
            count_q <= count_d;
            countUp_q <= countUp_d;
            cmpBufA_q <= cmpBufA_d;
            cmpBufB_q <= cmpBufB_d;
            cmpA_q <= cmpA_d;
            cmpB_q <= cmpB_d;
            blockMatch_q <= blockMatch_d;
            waveA_q <= waveA_d;
            waveB_q <= waveB_d;
            status_q <= status_d;
            mask_q <= mask_d;
            div_q <= div_d;
        end
    end

    // ==========================================================
    // Pin override and interrupt
    // ==========================================================
    // Any nonzero action hands the pin to the waveform bit; the
    // driver itself still obeys the port direction bit
    assign pinOutA = (actA != toc_pkg::ACT_OFF) ? waveA_q : portDataA;
    assign pinOeA = portDirA;
    assign pinOutB = (actB != toc_pkg::ACT_OFF) ? waveB_q : portDataB;
    assign pinOeB = portDirB;
    assign irq = |(status_q & mask_q);

    // ==========================================================
    // APB read side
    // ==========================================================
    assign pready = 1'b1;

    // Read mux; compare reads follow the CPU-visible register
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            toc_pkg::OFS_CTRL_A: prdata[7:0] = ctrlA_q;
            toc_pkg::OFS_CTRL_B: prdata[3:0] = ctrlB_q; // Force bits read 0
            toc_pkg::OFS_COUNT: prdata[7:0] = count_q;
            toc_pkg::OFS_CMP_A: prdata[7:0] = pwmMode ? cmpBufA_q : cmpA_q;
            toc_pkg::OFS_CMP_B: prdata[7:0] = pwmMode ? cmpBufB_q : cmpB_q;
            toc_pkg::OFS_STATUS: prdata[2:0] = status_q;
            toc_pkg::OFS_MASK: prdata[2:0] = mask_q;
            toc_pkg::OFS_PINS: begin
                prdata[toc_pkg::PIN_WAVE_A] = waveA_q;
                prdata[toc_pkg::PIN_WAVE_B] = waveB_q;
                prdata[toc_pkg::PIN_OVR_A] = (actA != toc_pkg::ACT_OFF);
                prdata[toc_pkg::PIN_OVR_B] = (actB != toc_pkg::ACT_OFF);
            end
            default: pslverr = psel && penable;
        endcase
    end

endmodule

// *** hdl/toc_pkg.sv ***
package toc_pkg;
    // ==========================================================
    // Register byte offsets on the APB
    // ==========================================================
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMP_A = 8'h0c;
    localparam logic [7:0] OFS_CMP_B = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_PINS = 8'h1c;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ACT_A_LSB = 6;          // Control A [7:6]
    localparam int ACT_B_LSB = 4;          // Control A [5:4]
    localparam int WGM_LO_LSB = 0;         // Control A [1:0]
    localparam int FORCE_A_BIT = 7;        // Control B
    localparam int FORCE_B_BIT = 6;        // Control B
    localparam int WGM_HI_BIT = 3;         // Control B
    localparam int CLKSEL_LSB = 0;         // Control B [2:0]
    localparam int EVT_MATCH_A = 0;        // Status and mask
    localparam int EVT_MATCH_B = 1;
    localparam int EVT_OVERFLOW = 2;
    localparam int PIN_WAVE_A = 0;         // Pins register
    localparam int PIN_WAVE_B = 1;
    localparam int PIN_OVR_A = 2;
    localparam int PIN_OVR_B = 3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [3:0] RST_CTRL_B = 4'h0;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CMP = 8'h00;
    localparam logic [2:0] RST_EVT = 3'h0;
    localparam logic RST_WAVE = 1'b0;

    // ==========================================================
    // Counting and prescaler constants
    // ==========================================================
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [5:0] DIV64_LAST = 6'h3f;
    localparam logic [7:0] DIV256_LAST = 8'hff;
    localparam logic [2:0] CLK_STOP = 3'h0;
    localparam logic [2:0] CLK_DIV1 = 3'h1;
    localparam logic [2:0] CLK_DIV8 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h3;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_CTC = 3'h2;

    // Compare output action codes
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
endpackage

// *** tb/toc_compare_unit_asserts.sv ***
`timescale 1ns/1ps
module toc_compare_unit_asserts (
    input wire logic clk_sys,        // System clock
    input wire logic rst_n,          // Sync reset, active low
    input wire logic psel,           // APB select
    input wire logic penable,        // APB access phase
    input wire logic pwrite,         // APB write
    input wire logic [7:0] paddr,    // APB address
    input wire logic [31:0] pwdata,  // APB write data
    input wire logic [31:0] prdata,  // APB read data
    input wire logic pready,         // APB ready
    input wire logic pslverr,        // APB error
    input wire logic portDataA,      // Port level A
    input wire logic portDirA,       // Port direction A
    input wire logic portDataB,      // Port level B
    input wire logic portDirB,       // Port direction B
    input wire logic pinOutA,        // Pin level A
    input wire logic pinOeA,         // Pin enable A
    input wire logic pinOutB,        // Pin level B
    input wire logic pinOeB,         // Pin enable B
    input wire logic irq             // Interrupt
);
    // ==========================================================
    // Access decode
    // ==========================================================
    // Zero-wait slave, so every access phase is a taken transfer
    wire logic accWr = psel && penable && pwrite;
    wire logic accRd = psel && penable && !pwrite;
    wire logic addrOk = (paddr[1:0] == 2'h0) && (paddr <= toc_pkg::OFS_PINS);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Properties
    // ==========================================================
    a_oe_dir_a: assert property (pinOeA == portDirA)
        else $error("pin A enable does not follow direction");
    a_oe_dir_b: assert property (pinOeB == portDirB)
        else $error("pin B enable does not follow direction");
    // First edge out of reset: pins on port level, interrupt low
    a_reset_port_lvl: assert property ($rose(rst_n) |->
        pinOutA == portDataA && pinOutB == portDataB && !irq)
        else $error("pins not on port level after reset");
    a_act_off_a: assert property (
        accWr && paddr == toc_pkg::OFS_CTRL_A && pwdata[7:6] == 2'h0 |=> pinOutA == portDataA)
        else $error("pin A still overridden after action off");
    a_act_off_b: assert property (
        accWr && paddr == toc_pkg::OFS_CTRL_A && pwdata[5:4] == 2'h0 |=> pinOutB == portDataB)
        else $error("pin B still overridden after action off");
    // Pin source must match the override and wave bits read back
    a_pin_source: assert property (accRd && paddr == toc_pkg::OFS_PINS |->
        pinOutA == (prdata[2] ? prdata[0] : portDataA)
        && pinOutB == (prdata[3] ? prdata[1] : portDataB))
        else $error("pin level disagrees with pins register");
    a_unmapped_err: assert property (
        accRd && !addrOk |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_ok: assert property (psel && penable && addrOk |-> !pslverr)
        else $error("mapped access flagged as error");
    a_force_rd_zero: assert property (
        accRd && paddr == toc_pkg::OFS_CTRL_B |-> prdata[7:6] == 2'h0)
        else $error("force strobes do not read zero");
    a_mask_irq_low: assert property (
        accWr && paddr == toc_pkg::OFS_MASK && pwdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt high with all events masked");
endmodule

bind toc_compare_unit toc_compare_unit_asserts u_asserts (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portDataA(portDataA), .portDirA(portDirA), .portDataB(portDataB), .portDirB(portDirB),
    .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOutB(pinOutB), .pinOeB(pinOeB), .irq(irq)
);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n, psel, penable, pwrite, portDataA, portDirA, portDataB, portDirB;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic pready, pslverr, pinOutA, pinOeA, pinOutB, pinOeB, irq, lastErr;
    logic [1:0] actSeq [4] = '{toc_pkg::ACT_SET, toc_pkg::ACT_TOGGLE, toc_pkg::ACT_TOGGLE,
        toc_pkg::ACT_CLEAR};
    logic [3:0] waveSeq = 4'h5;
    int n_fail = 0;
    int check_count = 0;

    // Clock, 100 MHz
    always #5 clk_sys = ~clk_sys;

    toc_compare_unit uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .portDataA(portDataA), .portDirA(portDirA), .portDataB(portDataB),
        .portDirB(portDirB), .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOutB(pinOutB),
        .pinOeB(pinOeB), .irq(irq)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; idle edge first so release and setup never collide
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rdData = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [31:0] msk,
        input logic [31:0] exp, input string name);
        apb(1'b0, addr, 32'h0);
        check(name, rdData & msk, exp);
    endtask

    // Load counter, idle while stopped, run at full rate, stop again
    task automatic run(input logic [7:0] cnt, input int idle, input int cycles);
        apb(1'b1, toc_pkg::OFS_COUNT, {24'h0, cnt});
        repeat (idle) @(posedge clk_sys);
        apb(1'b1, toc_pkg::OFS_CTRL_B, {29'h0, toc_pkg::CLK_DIV1});
        repeat (cycles) @(posedge clk_sys);
        apb(1'b1, toc_pkg::OFS_CTRL_B, 32'h0);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_reset();
        rd_check(toc_pkg::OFS_CTRL_A, 32'hffffffff, 32'h0, "ctrl_a");
        rd_check(toc_pkg::OFS_COUNT, 32'hff, 32'h0, "count");
        rd_check(toc_pkg::OFS_PINS, 32'hf, 32'h0, "pins");
        check("pin_b", 32'(pinOutB), 32'(portDataB));
        rd_check(8'h20, 32'hffffffff, 32'h0, "unmapped");
        check("slverr", 32'(lastErr), 32'h1);
        $display("test_reset done");
    endtask

    task automatic test_force();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, toc_pkg::OFS_CTRL_A, {24'h0, actSeq[i], 6'h0});
            apb(1'b1, toc_pkg::OFS_CTRL_B, 32'h80);
            // Override A set, wave B still low, wave A per action
            rd_check(toc_pkg::OFS_PINS, 32'hf, 32'h4 | {31'h0, waveSeq[i]}, "wave_a");
        end
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h30);
        apb(1'b1, toc_pkg::OFS_CTRL_B, 32'h40);
        rd_check(toc_pkg::OFS_PINS, 32'hf, 32'h0a, "wave_b");
        rd_check(toc_pkg::OFS_STATUS, 32'h7, 32'h0, "force_flag");
        rd_check(toc_pkg::OFS_COUNT, 32'hff, 32'h0, "force_cnt");
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'hc0);
        apb(1'b1, toc_pkg::OFS_CTRL_B, 32'h80);
        portDirA <= 1'b1;
        @(posedge clk_sys);
        #1;
        check("oe_a", 32'(pinOeA), 32'h1);
        check("pin_a_wave", 32'(pinOutA), 32'h1);
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h0);
        #1;
        check("pin_a_port", 32'(pinOutA), 32'h0);
        $display("test_force done");
    endtask

    task automatic test_ctc();
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h42);
        apb(1'b1, toc_pkg::OFS_CMP_A, 32'h05);
        apb(1'b0, toc_pkg::OFS_STATUS, 32'h0);
        run(8'h00, 0, 40);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h1, "ctc_flag");
        apb(1'b0, toc_pkg::OFS_COUNT, 32'h0);
        check("ctc_clear", 32'(rdData[7:0] <= 8'h05), 32'h1);
        $display("test_ctc done");
    endtask

    // Match on the tick right after a counter write must be lost
    task automatic test_block();
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h0);
        apb(1'b1, toc_pkg::OFS_CMP_A, 32'h20);
        apb(1'b0, toc_pkg::OFS_STATUS, 32'h0);
        run(8'h20, 20, 10);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h0, "blocked");
        run(8'h1f, 0, 10);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h1, "unblocked");
        $display("test_block done");
    endtask

    task automatic test_buffer();
        logic [31:0] wv;
        apb(1'b0, toc_pkg::OFS_PINS, 32'h0);
        wv = rdData & 32'h3;
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h03);
        rd_check(toc_pkg::OFS_PINS, 32'h3, wv, "wave_keep");
        apb(1'b1, toc_pkg::OFS_CTRL_A, wv[0] ? 32'h83 : 32'hc3);
        apb(1'b1, toc_pkg::OFS_CTRL_B, 32'h80);
        rd_check(toc_pkg::OFS_PINS, 32'h1, wv & 32'h1, "pwm_force");
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h03);
        apb(1'b1, toc_pkg::OFS_CMP_A, 32'h40);
        rd_check(toc_pkg::OFS_CMP_A, 32'hff, 32'h40, "cmp_buf");
        apb(1'b0, toc_pkg::OFS_STATUS, 32'h0);
        run(8'h3e, 0, 10);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h0, "no_load");
        run(8'hfc, 0, 10);
        apb(1'b0, toc_pkg::OFS_STATUS, 32'h0);
        run(8'h3e, 0, 10);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h1, "top_load");
        $display("test_buffer done");
    endtask

    task automatic test_irq();
        apb(1'b1, toc_pkg::OFS_MASK, 32'h1);
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h0);
        apb(1'b1, toc_pkg::OFS_CMP_A, 32'h40);
        run(8'h3e, 0, 10);
        #1;
        check("irq_set", 32'(irq), 32'h1);
        apb(1'b1, toc_pkg::OFS_MASK, 32'h0);
        #1;
        check("irq_masked", 32'(irq), 32'h0);
        apb(1'b1, toc_pkg::OFS_MASK, 32'h1);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h1, "irq_status");
        #1;
        check("irq_clear", 32'(irq), 32'h0);
        $display("test_irq done");
    endtask

    // Phase PWM loads the buffer only at top, then matches counting down
    task automatic test_phase();
        apb(1'b1, toc_pkg::OFS_CTRL_A, 32'h01);
        apb(1'b1, toc_pkg::OFS_CMP_A, 32'h10);
        apb(1'b0, toc_pkg::OFS_STATUS, 32'h0);
        run(8'h08, 0, 10);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h0, "phase_hold");
        run(8'hfd, 0, 10);
        apb(1'b0, toc_pkg::OFS_STATUS, 32'h0);
        run(8'h14, 0, 10);
        rd_check(toc_pkg::OFS_STATUS, 32'h1, 32'h1, "phase_load");
        $display("test_phase done");
    endtask

    // ==========================================================
    // Run control
    // ==========================================================
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog, well above the few hundred cycles the scenarios need
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        $display("ERROR watchdog expected finish seen timeout");
        stop_test();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        portDataA = 1'b0;
        portDirA = 1'b0;
        portDataB = 1'b1;
        portDirB = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        test_reset();
        test_force();
        test_ctc();
        test_block();
        test_buffer();
        test_irq();
        test_phase();
        stop_test();
    end
endmodule
